/* rsp_assertions.sv */
// Link checker for the host and device ends of the serial port.
// Assumes the bench wires it to the link interface signals directly.
`timescale 1ns/1ps
`default_nettype none
module rsp_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock history and rising edges counted within a frame.
    logic [5:0] hist;
    logic [5:0] next_hist;
    logic [7:0] rises;
    logic [7:0] next_rises;
    logic launch_ago;
    always_comb begin
        next_hist = {hist[4:0], sclk};
        next_rises = ce ? rises + {7'h00, sclk & ~hist[0]} : 8'h00;
        launch_ago = (hist[2] & ~hist[3]) | (hist[3] & ~hist[4]) | (hist[4] & ~hist[5]);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hist <= 6'h00;
            rises <= 8'h00;
        end else begin
            hist <= next_hist;
            rises <= next_rises;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Properties.
    sequence s_lead;
        !sclk [*8] ##1 sclk;
    endsequence
    sequence s_high;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence s_ce_low;
        !ce [*5];
    endsequence
    property p_idle_low;
        !ce |-> !sclk;
    endproperty
    property p_lead;
        $rose(ce) |-> s_lead;
    endproperty
    property p_high;
        $rose(sclk) |-> s_high;
    endproperty
    property p_si_hold;
        sclk && !$rose(sclk) |-> $stable(si);
    endproperty
    property p_oe_on;
        $rose(ce) |-> ##[2:4] !so_oe_b;
    endproperty
    property p_oe_off;
        s_ce_low |-> so_oe_b;
    endproperty
    property p_so_launch;
        ce && !so_oe_b && $past(!so_oe_b) && $changed(so) |-> launch_ago;
    endproperty
    property p_bytes;
        $fell(ce) |-> rises[2:0] == 3'h0;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("serial clock high outside a frame");
    a_lead: assert property (p_lead) else $error("first serial clock edge mistimed");
    a_high: assert property (p_high) else $error("serial clock high phase wrong");
    a_si_hold: assert property (p_si_hold) else $error("serial input moved while clock high");
    a_oe_on: assert property (p_oe_on) else $error("output not enabled after frame start");
    a_oe_off: assert property (p_oe_off) else $error("output still enabled after frame end");
    a_so_launch: assert property (p_so_launch) else $error("serial output changed off a rising edge");
    a_bytes: assert property (p_bytes) else $error("frame ended on a partial byte");
endmodule
`default_nettype wire

/* rsp_device.sv */
// Device end of the serial port: framing, format decode and alarm registers.
// Assumes link pins are asynchronous to clk and the host keeps its own framing.
`timescale 1ns/1ps
`default_nettype none
module rsp_device (
    input wire logic clk,
    input wire logic rst_b,
    rsp_if.dev link,
    input wire logic osc_stop,
    input wire logic [6:0] cur_min,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_day,
    output logic alarm_match
);
    typedef enum logic [4:0] {
        RSP_IDLE = 5'h01,
        RSP_CMD = 5'h02,
        RSP_WR = 5'h04,
        RSP_RD = 5'h08,
        RSP_SKIP = 5'h10
    } rsp_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.
    logic ce_s1, ce_s2, ce_q;
    logic sclk_s1, sclk_s2, sclk_q;
    logic si_s1, si_s2;
    logic ce_rise, sclk_rise, sclk_fall, sample, launch;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_s1 <= 1'b0;
            ce_s2 <= 1'b0;
            ce_q <= 1'b0;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_q <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            ce_s1 <= link.ce;
            ce_s2 <= ce_s1;
            ce_q <= ce_s2;
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_q <= sclk_s2;
            si_s1 <= link.si;
            si_s2 <= si_s1;
        end
    end

    logic mode_rise;
    assign ce_rise = ce_s2 & ~ce_q;
    assign sclk_rise = sclk_s2 & ~sclk_q;
    assign sclk_fall = ~sclk_s2 & sclk_q;
    assign sample = mode_rise ? sclk_rise : sclk_fall; // RQ1 RQ2
    assign launch = mode_rise ? sclk_fall : sclk_rise; // RQ1 RQ2

    ////////////////////////////////////////////////////////////////////////
    // Framing, shifting and register access.
    rsp_state_t state, next_state;
    logic next_mode_rise;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] tx, next_tx;
    logic [3:0] ptr, next_ptr;
    logic burst, next_burst;
    logic so, next_so;
    logic so_oe_b, next_so_oe_b;
    logic [7:0] alarm_reg [0:2];
    logic [7:0] next_alarm_reg [0:2];
    logic match, next_match;
    logic [7:0] byte_in;

    function automatic logic [1:0] reg_index(input logic [3:0] addr);
        reg_index = 2'(addr - rsp_pkg::ADDR_WEEKDAY);
    endfunction

    function automatic logic reg_hit(input logic [3:0] addr);
        reg_hit = (addr >= rsp_pkg::ADDR_WEEKDAY) && (addr <= rsp_pkg::ADDR_HOUR);
    endfunction

    function automatic logic [7:0] reg_mask(input logic [3:0] addr);
        unique case (addr)
            rsp_pkg::ADDR_WEEKDAY: reg_mask = rsp_pkg::MASK_WEEKDAY;
            rsp_pkg::ADDR_MINUTE: reg_mask = rsp_pkg::MASK_MINUTE;
            rsp_pkg::ADDR_HOUR: reg_mask = rsp_pkg::MASK_HOUR;
            default: reg_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] read_reg(input logic [3:0] addr, input logic [7:0] r0,
                                            input logic [7:0] r1, input logic [7:0] r2);
        logic [7:0] v;
        v = 8'h00;
        if (reg_hit(addr)) begin
            unique case (reg_index(addr))
                2'h0: v = r0;
                2'h1: v = r1;
                default: v = r2;
            endcase
        end
        read_reg = v & reg_mask(addr); // RQ13 RQ14 RQ17
    endfunction

    assign byte_in = {shreg[6:0], si_s2};

    always_comb begin
        next_state = state;
        next_mode_rise = mode_rise;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_tx = tx;
        next_ptr = ptr;
        next_burst = burst;
        next_so = so;
        next_so_oe_b = so_oe_b;
        for (int i = 0; i < 3; i++) begin
            next_alarm_reg[i] = osc_stop ? rsp_pkg::RESET_VALUE : alarm_reg[i]; // RQ17
        end
        if (!ce_s2) begin
            next_state = RSP_IDLE; // RQ3 RQ20
            next_bitcnt = 3'h0;
            next_so_oe_b = 1'b1;
            next_so = 1'b0;
        end else if (ce_rise) begin
            next_state = RSP_CMD; // RQ3
            next_mode_rise = sclk_s2; // RQ1 RQ2
            next_bitcnt = 3'h0;
            next_so_oe_b = 1'b0;
            next_so = 1'b0;
        end else begin
            if (launch && state == RSP_RD) begin
                next_so = tx[7]; // RQ5
                next_tx = {tx[6:0], 1'b0};
            end
            if (sample && state != RSP_IDLE) begin
                next_shreg = byte_in; // RQ5
                next_bitcnt = 3'(bitcnt + 3'h1);
                if (bitcnt == 3'h7) begin
                    unique case (state)
                        RSP_CMD: begin
                            next_ptr = byte_in[7:4]; // RQ4
                            next_burst = ~byte_in[rsp_pkg::FMT_ONE_BIT]; // RQ4
                            unique case (byte_in[3:0])
                                rsp_pkg::FMT_WR_ONE, rsp_pkg::FMT_WR_BURST: begin
                                    next_state = RSP_WR; // RQ6 RQ7
                                end
                                rsp_pkg::FMT_RD_ONE, rsp_pkg::FMT_RD_BURST: begin
                                    next_state = RSP_RD; // RQ8 RQ9
                                    next_tx = read_reg(byte_in[7:4], alarm_reg[0], alarm_reg[1], alarm_reg[2]);
                                end
                                default: next_state = RSP_SKIP;
                            endcase
                        end
                        RSP_WR: begin
                            if (reg_hit(ptr) && !osc_stop) begin
                                next_alarm_reg[reg_index(ptr)] = byte_in & reg_mask(ptr); // RQ20 RQ13 RQ14
                            end
                            if (burst) begin
                                next_ptr = 4'(ptr + 4'h1); // RQ7 RQ10 RQ11
                            end else begin
                                next_state = RSP_CMD; // RQ6 RQ19
                            end
                        end
                        RSP_RD: begin
                            if (burst) begin
                                next_ptr = 4'(ptr + 4'h1); // RQ9 RQ10 RQ12
                                next_tx = read_reg(4'(ptr + 4'h1), alarm_reg[0], alarm_reg[1], alarm_reg[2]);
                            end else begin
                                next_state = RSP_CMD; // RQ8 RQ19
                            end
                        end
                        RSP_SKIP: next_state = RSP_SKIP;
                        default: next_state = RSP_IDLE;
                    endcase
                end
            end
        end
        next_match = (cur_min == alarm_reg[1][6:0]) && (cur_hour == alarm_reg[2][5:0])
                     && ((cur_day & alarm_reg[0][6:0]) != 7'h00); // RQ15 RQ18
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= RSP_IDLE;
            mode_rise <= 1'b0;
            bitcnt <= 3'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 4'h0;
            burst <= 1'b0;
            so <= 1'b0;
            so_oe_b <= 1'b1;
            match <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                alarm_reg[i] <= rsp_pkg::RESET_VALUE;
            end
        end else begin
            state <= next_state;
            mode_rise <= next_mode_rise;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            tx <= next_tx;
            ptr <= next_ptr;
            burst <= next_burst;
            so <= next_so;
            so_oe_b <= next_so_oe_b;
            match <= next_match;
            for (int i = 0; i < 3; i++) begin
                alarm_reg[i] <= next_alarm_reg[i];
            end
        end
    end

    assign link.so = so;
    assign link.so_oe_b = so_oe_b;
    assign alarm_match = match;
endmodule
`default_nettype wire

/* rsp_host.sv */
// Host end of the serial port, with a write-data FIFO in front of the link.
// Assumes the device follows the framing and samples on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module rsp_fifo #(
    parameter int WIDTH = rsp_pkg::FIFO_WIDTH,
    parameter int DEPTH = rsp_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic full, empty, next_full, next_empty, push, pop;
    logic room, next_room;

    assign push = in_valid & ~full;
    assign pop = out_ready & ~empty;

    always_comb begin
        next_wp = push ? ((wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1)) : wp;
        next_rp = pop ? ((rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1)) : rp;
        next_cnt = (AW + 1)'(cnt + (AW + 1)'(push) - (AW + 1)'(pop));
        next_full = (next_cnt == (AW + 1)'(DEPTH));
        next_empty = (next_cnt == '0);
        next_room = ~next_full;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            full <= 1'b0;
            empty <= 1'b1;
            room <= 1'b1;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            full <= next_full;
            empty <= next_empty;
            room <= next_room;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    assign in_ready = room;
    assign out_valid = ~empty;
    assign out_data = mem[rp];
endmodule

////////////////////////////////////////////////////////////////////////////
module rsp_host #(
    parameter int HALF = rsp_pkg::SCLK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    rsp_if.host link,
    input wire logic start,
    input wire logic [3:0] start_addr,
    input wire logic [3:0] start_fmt,
    input wire logic [5:0] start_len,
    output logic busy,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    typedef enum logic [4:0] {
        HST_IDLE = 5'h01,
        HST_SETUP = 5'h02,
        HST_HIGH = 5'h04,
        HST_LOW = 5'h08,
        HST_END = 5'h10
    } rsp_hstate_t;

    logic so_s1, so_s2;
    logic f_valid, f_pop;
    logic [7:0] f_data;

    rsp_fifo #(.WIDTH(rsp_pkg::FIFO_WIDTH), .DEPTH(rsp_pkg::FIFO_DEPTH)) i_rsp_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    rsp_hstate_t state, next_state;
    logic [7:0] timer, next_timer, sh, next_sh, next_rd_data;
    logic [2:0] bitcnt, next_bitcnt;
    logic [5:0] left, next_left;
    logic is_read, next_is_read, is_cmd, next_is_cmd;
    logic ce, next_ce, sclk, next_sclk, si, next_si;
    logic next_busy, next_rd_valid, tdone, need_data;

    assign tdone = (timer == 8'(HALF - 1));
    assign need_data = ~is_cmd & ~is_read & (bitcnt == 3'h0);

    always_comb begin
        next_state = state;
        next_timer = tdone ? timer : 8'(timer + 8'h01);
        next_sh = sh;
        next_bitcnt = bitcnt;
        next_left = left;
        next_is_read = is_read;
        next_is_cmd = is_cmd;
        next_ce = ce;
        next_sclk = sclk;
        next_si = si;
        next_busy = busy;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        f_pop = 1'b0;
        unique case (state)
            HST_IDLE: begin
                if (start) begin
                    next_sh = {start_addr, start_fmt}; // RQ4
                    next_left = start_len;
                    next_is_read = start_fmt[rsp_pkg::FMT_READ_BIT];
                    next_is_cmd = 1'b1;
                    next_ce = 1'b1; // RQ3 RQ1
                    next_busy = 1'b1;
                    next_timer = 8'h00;
                    next_state = HST_SETUP;
                end
            end
            HST_SETUP, HST_LOW: begin
                if (tdone) begin
                    if (state == HST_LOW && ~is_cmd && bitcnt == 3'h0 && left == 6'h00) begin
                        next_timer = 8'h00;
                        next_state = HST_END; // RQ11 RQ12
                    end else if (need_data) begin
                        if (f_valid) begin
                            f_pop = 1'b1;
                            next_sh = f_data;
                            next_si = f_data[7]; // RQ5
                            next_sclk = 1'b1;
                            next_timer = 8'h00;
                            next_state = HST_HIGH;
                        end
                    end else begin
                        next_si = sh[7]; // RQ5
                        next_sclk = 1'b1;
                        next_timer = 8'h00;
                        next_state = HST_HIGH;
                    end
                end
            end
            HST_HIGH: begin
                if (tdone) begin
                    next_sclk = 1'b0;
                    next_sh = {sh[6:0], so_s2}; // RQ5
                    next_bitcnt = 3'(bitcnt + 3'h1);
                    if (bitcnt == 3'h7) begin
                        if (is_cmd) begin
                            next_is_cmd = 1'b0; // RQ19
                        end else begin
                            next_left = 6'(left - 6'h01);
                            if (is_read) begin
                                next_rd_valid = 1'b1;
                                next_rd_data = {sh[6:0], so_s2};
                            end
                        end
                    end
                    next_timer = 8'h00;
                    next_state = HST_LOW;
                end
            end
            HST_END: begin
                if (tdone) begin
                    next_timer = 8'h00;
                    if (ce) begin
                        next_ce = 1'b0; // RQ3
                    end else begin
                        next_busy = 1'b0;
                        next_state = HST_IDLE;
                    end
                end
            end
            default: next_state = HST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            so_s1 <= 1'b0;
            so_s2 <= 1'b0;
            state <= HST_IDLE;
            timer <= 8'h00;
            sh <= 8'h00;
            bitcnt <= 3'h0;
            left <= 6'h00;
            is_read <= 1'b0;
            is_cmd <= 1'b0;
            ce <= 1'b0;
            sclk <= 1'b0;
            si <= 1'b0;
            busy <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            so_s1 <= link.so;
            so_s2 <= so_s1;
            state <= next_state;
            timer <= next_timer;
            sh <= next_sh;
            bitcnt <= next_bitcnt;
            left <= next_left;
            is_read <= next_is_read;
            is_cmd <= next_is_cmd;
            ce <= next_ce;
            sclk <= next_sclk;
            si <= next_si;
            busy <= next_busy;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    assign link.ce = ce;
    assign link.sclk = sclk;
    assign link.si = si;
endmodule
`default_nettype wire

/* rsp_if.sv */
// Four-wire serial link between the host end and the device end.
// Assumes so carries meaning only while so_oe_b is low.
`timescale 1ns/1ps
`default_nettype none
interface rsp_if;
    logic ce;
    logic sclk;
    logic si;
    logic so;
    logic so_oe_b;
    modport dev (input ce, input sclk, input si, output so, output so_oe_b);
    modport host (output ce, output sclk, output si, input so, input so_oe_b);
endinterface
`default_nettype wire

/* rsp_pkg.sv */
// Shared constants for the four-wire serial port of the real-time clock.
// Assumes a 20 MHz system clock at both ends and the serial link in rsp_if.
//
// How it works
// [RQ1] Clock low at enable rise: sample falling.
// [RQ2] Clock high at enable rise: sample rising.
// [RQ3] Enable rising starts, falling ends a transfer.
// [RQ4] First byte: head address, then format code.
// [RQ5] All bytes travel most significant bit first.
// [RQ6] Format 8h writes one byte only.
// [RQ7] Format 0h burst writes, pointer advances.
// [RQ8] Format Ch reads one byte only.
// [RQ9] Format 4h burst reads consecutive addresses.
// [RQ10] Burst pointer increments, wraps Fh to 0h.
// [RQ11] Host ends burst write by dropping enable.
// [RQ12] Host ends burst read by dropping enable.
// [RQ13] Alarm minute: bits 6..0, bit 7 zero.
// [RQ14] Alarm hour: bits 7..6 zero, bit 5 dual.
// [RQ15] Twelve-hour midnight is 12, noon is 32.
// [RQ16] Host avoids writing non-existent alarm times.
// [RQ17] After oscillator stop, values undefined, upper zero.
// [RQ18] Seven weekday enables, day mapping left free.
// [RQ19] One-byte formats chain within one enable.
// [RQ20] Write lands only after eight full bits.
`default_nettype none
package rsp_pkg;
    localparam logic [3:0] ADDR_WEEKDAY = 4'hA;
    localparam logic [3:0] ADDR_MINUTE = 4'hB;
    localparam logic [3:0] ADDR_HOUR = 4'hC;
    localparam logic [7:0] MASK_WEEKDAY = 8'h7F;
    localparam logic [7:0] MASK_MINUTE = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [3:0] FMT_WR_ONE = 4'h8;
    localparam logic [3:0] FMT_WR_BURST = 4'h0;
    localparam logic [3:0] FMT_RD_ONE = 4'hC;
    localparam logic [3:0] FMT_RD_BURST = 4'h4;
    localparam int FMT_ONE_BIT = 3;
    localparam int FMT_READ_BIT = 2;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;
endpackage
`default_nettype wire

/* rtc_four_wire_serial_port_bench.sv */
// Bench joining host and device ends through the link interface.
// Assumes the package, interface, host, FIFO and device are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define RSP_CHK(what, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
end
module rtc_four_wire_serial_port_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [3:0] start_addr = 4'h0;
    logic [3:0] start_fmt = 4'h0;
    logic [5:0] start_len = 6'h00;
    logic busy;
    logic wr_valid = 1'b0;
    logic wr_ready;
    logic [7:0] wr_data = 8'h00;
    logic rd_valid;
    logic [7:0] rd_data;
    logic osc_stop = 1'b0;
    logic [6:0] cur_min = 7'h00;
    logic [5:0] cur_hour = 6'h00;
    logic [6:0] cur_day = 7'h00;
    logic alarm_match;
    logic [7:0] rq[$];
    int fail_count = 0;
    int total_checks = 0;

    rsp_if i_rsp_if ();
    rsp_host i_rsp_host (.clk(clk), .rst_b(rst_b), .link(i_rsp_if.host), .start(start),
        .start_addr(start_addr), .start_fmt(start_fmt), .start_len(start_len), .busy(busy),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_data(rd_data));
    rsp_device i_rsp_device (.clk(clk), .rst_b(rst_b), .link(i_rsp_if.dev), .osc_stop(osc_stop),
        .cur_min(cur_min), .cur_hour(cur_hour), .cur_day(cur_day), .alarm_match(alarm_match));
    rsp_assertions i_rsp_assertions (.clk(clk), .rst_b(rst_b), .ce(i_rsp_if.ce), .sclk(i_rsp_if.sclk),
        .si(i_rsp_if.si), .so(i_rsp_if.so), .so_oe_b(i_rsp_if.so_oe_b));

    initial begin
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Checks made %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timed_out(input string what);
        fail_count++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        tally_and_finish();
    endtask
    task automatic xfer(input logic [3:0] a, input logic [3:0] f, input logic [5:0] n);
        int i;
        rq.delete();
        start = 1'b1;
        start_addr = a;
        start_fmt = f;
        start_len = n;
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) timed_out("busy");
        @(negedge clk);
    endtask
    task automatic fill(input int n, input logic [7:0] base);
        int i;
        int k;
        for (k = 0; k < n; k++) begin
            for (i = 0; i < 4000 && wr_ready !== 1'b1; i++) begin
                wr_valid = 1'b0;
                @(negedge clk);
            end
            if (wr_ready !== 1'b1) timed_out("wr_ready");
            wr_valid = 1'b1;
            wr_data = base + k[7:0];
            @(negedge clk);
        end
        wr_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic reset_values();
        xfer(rsp_pkg::ADDR_HOUR, rsp_pkg::FMT_RD_ONE, 6'd1);
        `RSP_CHK("hour after reset", 8'h00, rq[0])
        `RSP_CHK("one byte read count", 1, rq.size())
    endtask
    task automatic single_bytes();
        fill(1, 8'hD9);
        fill(1, {rsp_pkg::ADDR_HOUR, rsp_pkg::FMT_WR_ONE});
        fill(1, 8'hF2);
        xfer(rsp_pkg::ADDR_MINUTE, rsp_pkg::FMT_WR_ONE, 6'd3);
        fill(1, 8'h11);
        xfer(rsp_pkg::ADDR_MINUTE, 4'h2, 6'd1);
        xfer(rsp_pkg::ADDR_MINUTE, rsp_pkg::FMT_RD_ONE, 6'd1);
        `RSP_CHK("minute top bit", 8'h59, rq[0])
        xfer(rsp_pkg::ADDR_HOUR, rsp_pkg::FMT_RD_ONE, 6'd1);
        `RSP_CHK("chained hour top bits", 8'h32, rq[0])
    endtask
    task automatic fifo_burst_wrap();
        int i;
        logic [7:0] e;
        fill(32, 8'h95);
        `RSP_CHK("fifo full", 1'b0, wr_ready)
        xfer(4'h0, rsp_pkg::FMT_WR_BURST, 6'd32);
        `RSP_CHK("fifo drained", 1'b1, wr_ready)
        xfer(4'hF, rsp_pkg::FMT_RD_BURST, 6'd14);
        for (i = 0; i < 14; i++) begin
            e = (i == 11) ? 8'h2F : (i == 12) ? 8'h30 : (i == 13) ? 8'h31 : 8'h00;
            `RSP_CHK("burst read", e, rq[i])
        end
    endtask
    task automatic mid_reset();
        start_addr = rsp_pkg::ADDR_WEEKDAY;
        start_fmt = rsp_pkg::FMT_RD_BURST;
        start_len = 6'd8;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (100) @(negedge clk);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        `RSP_CHK("busy in reset", 1'b0, busy)
        `RSP_CHK("enable in reset", 1'b0, i_rsp_if.ce)
        rst_b = 1'b1;
        @(negedge clk);
        xfer(rsp_pkg::ADDR_HOUR, rsp_pkg::FMT_RD_ONE, 6'd1);
        `RSP_CHK("hour after mid reset", rsp_pkg::RESET_VALUE, rq[0])
    endtask
    task automatic alarm_and_stop();
        int i;
        fill(3, 8'h00);
        xfer(rsp_pkg::ADDR_WEEKDAY, rsp_pkg::FMT_WR_BURST, 6'd3);
        fill(1, 8'h01);
        xfer(rsp_pkg::ADDR_WEEKDAY, rsp_pkg::FMT_WR_ONE, 6'd1);
        fill(2, 8'h31);
        xfer(rsp_pkg::ADDR_MINUTE, rsp_pkg::FMT_WR_BURST, 6'd2);
        xfer(rsp_pkg::ADDR_MINUTE, rsp_pkg::FMT_RD_BURST, 6'd2);
        `RSP_CHK("alarm minute", 8'h31, rq[0])
        `RSP_CHK("noon code", 8'h32, rq[1])
        cur_min = 7'h31;
        cur_hour = 6'h32;
        cur_day = 7'h01;
        repeat (4) @(negedge clk);
        `RSP_CHK("alarm hit", 1'b1, alarm_match)
        cur_day = 7'h02;
        repeat (4) @(negedge clk);
        `RSP_CHK("alarm other day", 1'b0, alarm_match)
        osc_stop = 1'b1;
        repeat (3) @(negedge clk);
        osc_stop = 1'b0;
        xfer(rsp_pkg::ADDR_WEEKDAY, rsp_pkg::FMT_RD_BURST, 6'd3);
        for (i = 0; i < 3; i++) begin
            `RSP_CHK("cleared by stop", 8'h00, rq[i])
        end
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        reset_values();
        single_bytes();
        fifo_burst_wrap();
        mid_reset();
        alarm_and_stop();
        tally_and_finish();
    end
endmodule
`default_nettype wire
